// ### core/phy_general_config_ctrl.sv
// Summary of operation
// - Blink period field picks 50, 100, 200 or 500 ms; resets to 2.
// - Stretch bypass bit set drives LEDs unstretched; clear keeps normal stretching.
// - Quick negotiation enable with timer select 0 shortest to 3 longest.
// - Bit 11 allows full duplex on parallel-detect links, otherwise half duplex.
// - Writing one to status clear bit clears PHY status register bits.
// - Bit 9 enables robust crossover resolution; resets to zero.
// - Bit 8 enables quick crossover mode; resets to zero.
// - Bit 7 makes the shared pad an interrupt output, else power-down input.
// - Force interrupt bit asserts the interrupt pad whenever bit 7 selects interrupt output.
// - Bit 3 with manual 1G speed runs negotiation advertising only 1G.
// - Writing one to bit 0 starts cable test; hardware clears on completion.
// - Writing bit 15 resets PHY and all registers; bit self clears.
// - Soft full reset reloads latched strap values for strapped fields.
// - Writing bit 14 restarts PHY, registers kept; bit self clears.
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none

module phy_general_config_ctrl #(
  parameter int unsigned  BLINK_HALF_0 = phy_cfg_pkg::BLINK_HALF_0,
  parameter int unsigned  BLINK_HALF_1 = phy_cfg_pkg::BLINK_HALF_1,
  parameter int unsigned  BLINK_HALF_2 = phy_cfg_pkg::BLINK_HALF_2,
  parameter int unsigned  BLINK_HALF_3 = phy_cfg_pkg::BLINK_HALF_3,
  parameter logic [15:0]  STRAP_MASK   = 16'h0000
) (
  input  wire logic        clk,                   // core clock, 250 MHz
  input  wire logic        rstn,                  // asynchronous reset, active low
  input  wire logic [4:0]  reg_addr,              // register address
  input  wire logic [15:0] reg_wdata,             // write data
  input  wire logic        reg_wr,                // write strobe
  input  wire logic        reg_rd,                // read strobe
  output var  logic [15:0] reg_rdata,             // read data, cycle after strobe
  input  wire logic [15:0] strap_cfg4,            // strap levels for strapped fields
  output var  logic        led_blink,             // LED blink phase
  output var  logic        led_stretch_bypass,    // LEDs unstretched
  output var  logic        quick_negotiation_enable,     // short negotiation timers
  output var  logic [1:0]  quick_negotiation_timer_sel,  // timer length choice
  output var  logic        parallel_detect_full_duplex_enable, // FD on parallel detect
  output var  logic        robust_crossover_enable, // robust crossover
  output var  logic        quick_crossover_enable,  // quick crossover
  input  wire logic        manual_speed_1g,       // manual speed is 1G
  output var  logic        neg_gig_only,          // negotiate advertising 1G only
  output var  logic        neg_skip,              // manual 1G without negotiation
  output var  logic        phy_status_clear,      // clear PHY status bits, pulse
  output var  logic        phy_full_reset,        // PHY soft full reset, pulse
  output var  logic        phy_relaunch,          // PHY restart, pulse
  output var  logic        cable_test_run,        // test engine running
  input  wire logic        cable_test_eng_done,   // engine completion pulse
  input  wire logic        cable_test_eng_fail,   // engine verdict
  input  wire logic        phy_irq_req,           // PHY interrupt request
  input  wire logic        irq_or_powerdown_pad_i,    // pad level in
  output var  logic        irq_or_powerdown_pad_o,    // pad level out
  output var  logic        irq_or_powerdown_pad_oe_n, // pad drive, low drives
  output var  logic        power_down_req,        // power-down requested by pad
  output var  logic        irq                    // block interrupt, level
);

  // Straps cannot reach the cable test start, done and fail bits (2:0) of cfg4.
  if ((STRAP_MASK & ~phy_cfg_pkg::CFG4_WR_MASK) != 16'h0000)
  begin : g_bad_strap
    $error("strap mask covers read-only bits");
  end

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Straps are caught once after hardware reset release; a soft full reset
  // reuses the held copy, since the pins may be repurposed by then.
  logic        strap_taken_ff;
  logic [15:0] strap_ff;

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      strap_taken_ff <= 1'b0;
      strap_ff       <= 16'h0000;
    end
    else if (!strap_taken_ff)
    begin
      strap_taken_ff <= 1'b1;
      strap_ff       <= strap_cfg4;
    end
  end

  logic [15:0] cfg4_default;
  assign cfg4_default = (phy_cfg_pkg::CFG4_RST & ~STRAP_MASK) | (strap_ff & STRAP_MASK);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit_led;
  logic hit_cfg4;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;

  logic wr_led;
  logic wr_cfg4;
  logic wr_ctrl;
  logic wr_mask;

  logic rd_stat;

  assign hit_led  = reg_addr == phy_cfg_pkg::LED_CFG3_ADDR;
  assign hit_cfg4 = reg_addr == phy_cfg_pkg::CFG4_ADDR;
  assign hit_ctrl = reg_addr == phy_cfg_pkg::CTRL_ADDR;
  assign hit_stat = reg_addr == phy_cfg_pkg::INT_STATUS_ADDR;
  assign hit_mask = reg_addr == phy_cfg_pkg::INT_MASK_ADDR;

  // Unmapped offsets match no decode, so such writes are lost.
  assign wr_led   = reg_wr & hit_led;
  assign wr_cfg4  = reg_wr & hit_cfg4;
  assign wr_ctrl  = reg_wr & hit_ctrl;
  assign wr_mask  = reg_wr & hit_mask;

  assign rd_stat  = reg_rd & hit_stat;

  // ----------------------------------------------------------------
  // Command strobes
  // ----------------------------------------------------------------
  logic full_reset_req;
  logic relaunch_req;

  logic status_clr_req;
  logic test_start_req;

  assign full_reset_req = wr_ctrl & reg_wdata[phy_cfg_pkg::FULL_RESET_BIT];
  assign relaunch_req   = wr_ctrl & reg_wdata[phy_cfg_pkg::RELAUNCH_BIT];

  assign status_clr_req = wr_cfg4 & reg_wdata[phy_cfg_pkg::STATUS_CLR_BIT];
  assign test_start_req = wr_cfg4 & reg_wdata[phy_cfg_pkg::TEST_START_BIT];

  // ----------------------------------------------------------------
  // Cable test sequencer
  // ----------------------------------------------------------------
  cable_test_if ct ();

  // A start while a test runs is ignored rather than restarting the engine.
  assign ct.start = test_start_req & ~ct.busy;

  cable_test_seq u_test (
    .clk      (clk),
    .rst_n    (rst_n_ff),
    .abort    (full_reset_req),
    .ct       (ct.seq),
    .eng_run  (cable_test_run),
    .eng_done (cable_test_eng_done),
    .eng_fail (cable_test_eng_fail)
  );

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0]              led_ff;
  logic [15:0]              cfg4_ff;
  logic [15:0]              ctrl_ff;
  logic [phy_cfg_pkg::EVT_W-1:0] mask_ff;
  logic [phy_cfg_pkg::EVT_W-1:0] stat_ff;

  logic [15:0]              nxt_led;
  logic [15:0]              nxt_cfg4;
  logic [15:0]              nxt_ctrl;
  logic [phy_cfg_pkg::EVT_W-1:0] nxt_mask;
  logic [phy_cfg_pkg::EVT_W-1:0] nxt_stat;

  logic [phy_cfg_pkg::EVT_W-1:0] events;

  assign events[phy_cfg_pkg::EVT_TEST_DONE]  = ct.done_evt;
  assign events[phy_cfg_pkg::EVT_TEST_FAIL]  = ct.done_evt & ct.fail;
  assign events[phy_cfg_pkg::EVT_RELAUNCH]   = relaunch_req;
  assign events[phy_cfg_pkg::EVT_STATUS_CLR] = status_clr_req;

  // Reserved read/write bits are stored as written; software keeps them.
  always_comb
  begin
    nxt_led  = wr_led ? (reg_wdata & phy_cfg_pkg::LED_WR_MASK) : led_ff;
    nxt_cfg4 = wr_cfg4 ? (reg_wdata & phy_cfg_pkg::CFG4_WR_MASK) : cfg4_ff;
    nxt_ctrl = wr_ctrl ? (reg_wdata & phy_cfg_pkg::CTRL_WR_MASK) : ctrl_ff;
    nxt_mask = wr_mask ? reg_wdata[phy_cfg_pkg::EVT_W-1:0] : mask_ff;

    // An event landing with the clearing read is kept.
    nxt_stat = (rd_stat ? '0 : stat_ff) | events;

    if (full_reset_req)
    begin
      nxt_led  = phy_cfg_pkg::LED_CFG3_RST;
      nxt_cfg4 = cfg4_default & phy_cfg_pkg::CFG4_WR_MASK;
      nxt_ctrl = phy_cfg_pkg::CTRL_RST;
      nxt_mask = phy_cfg_pkg::INT_MASK_RST[phy_cfg_pkg::EVT_W-1:0];
      nxt_stat = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      led_ff  <= phy_cfg_pkg::LED_CFG3_RST;
      cfg4_ff <= phy_cfg_pkg::CFG4_RST & phy_cfg_pkg::CFG4_WR_MASK;
      ctrl_ff <= phy_cfg_pkg::CTRL_RST;
      mask_ff <= phy_cfg_pkg::INT_MASK_RST[phy_cfg_pkg::EVT_W-1:0];
      stat_ff <= '0;
    end
    else if (!strap_taken_ff)
    begin
      // Strapped fields take the pins on the first edge after release.
      cfg4_ff <= (phy_cfg_pkg::CFG4_RST & ~STRAP_MASK | strap_cfg4 & STRAP_MASK)
                 & phy_cfg_pkg::CFG4_WR_MASK;
    end
    else
    begin
      led_ff  <= nxt_led;
      cfg4_ff <= nxt_cfg4;
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
    end
  end

  // ----------------------------------------------------------------
  // LED blink
  // ----------------------------------------------------------------
  led_blink_gen #(
    .HALF_0 (BLINK_HALF_0),
    .HALF_1 (BLINK_HALF_1),
    .HALF_2 (BLINK_HALF_2),
    .HALF_3 (BLINK_HALF_3)
  ) u_blink (
    .clk   (clk),
    .rst_n (rst_n_ff),
    .sel   (led_ff[phy_cfg_pkg::LED_RATE_LSB +: 2]),
    .blink (led_blink)
  );

  assign led_stretch_bypass = led_ff[phy_cfg_pkg::LED_BYPASS_BIT];

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  assign quick_negotiation_enable    = cfg4_ff[phy_cfg_pkg::QNEG_EN_BIT];
  assign quick_negotiation_timer_sel = cfg4_ff[phy_cfg_pkg::QNEG_SEL_LSB +: 2];

  assign parallel_detect_full_duplex_enable = cfg4_ff[phy_cfg_pkg::PD_FULL_BIT];
  assign robust_crossover_enable     = cfg4_ff[phy_cfg_pkg::ROBUST_XOVER_BIT];
  assign quick_crossover_enable      = cfg4_ff[phy_cfg_pkg::QUICK_XOVER_BIT];

  // ----------------------------------------------------------------
  // Pulses, negotiation mode, pad and interrupt
  // ----------------------------------------------------------------
  logic irq_any;
  logic pad_irq_mode;
  logic pad_assert;
  logic gig_only_req;

  // Next-state values keep pad and irq level with the registers.
  assign irq_any      = |(nxt_stat & nxt_mask);
  assign pad_irq_mode = nxt_cfg4[phy_cfg_pkg::PAD_IRQ_BIT];
  assign pad_assert   = nxt_cfg4[phy_cfg_pkg::FORCE_IRQ_BIT] | irq_any | phy_irq_req;

  assign gig_only_req = nxt_cfg4[phy_cfg_pkg::GIG_ONLY_BIT];

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      phy_status_clear          <= 1'b0;
      phy_full_reset            <= 1'b0;
      phy_relaunch              <= 1'b0;

      neg_gig_only              <= 1'b0;
      neg_skip                  <= 1'b0;
      irq_or_powerdown_pad_o    <= 1'b1;
      irq_or_powerdown_pad_oe_n <= 1'b1;
      power_down_req            <= 1'b0;
      irq                       <= 1'b0;
    end
    else
    begin
      phy_status_clear          <= status_clr_req;
      phy_full_reset            <= full_reset_req;
      phy_relaunch              <= relaunch_req;

      neg_gig_only              <= manual_speed_1g & gig_only_req;
      neg_skip                  <= manual_speed_1g & ~gig_only_req;
      irq_or_powerdown_pad_o    <= ~pad_assert;
      irq_or_powerdown_pad_oe_n <= ~pad_irq_mode;
      power_down_req            <= ~pad_irq_mode & ~irq_or_powerdown_pad_i;
      irq                       <= irq_any;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] cfg4_view;
  logic [15:0] rd_mux;

  // Done mirrors an idle sequencer, so it reads one after any reset.
  assign cfg4_view = {cfg4_ff[15:3], ct.fail, ~ct.busy, ct.busy};

  // Both command bits read zero: their effect is a pulse, never a held state.
  assign rd_mux = hit_led  ? led_ff :
                  hit_cfg4 ? cfg4_view :
                  hit_ctrl ? ctrl_ff :
                  hit_stat ? {12'h000, stat_ff} :
                  hit_mask ? {12'h000, mask_ff} : 16'h0000;

  // Idle cycles return zero, so a stale word never looks valid.
  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

endmodule : phy_general_config_ctrl

`default_nettype wire

// ### core/phy_cfg_pkg.sv
`default_nettype none

package phy_cfg_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned EVT_W  = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] LED_CFG3_ADDR   = 5'h1A;
  localparam logic [4:0] INT_STATUS_ADDR = 5'h1B;
  localparam logic [4:0] INT_MASK_ADDR   = 5'h1C;
  localparam logic [4:0] CFG4_ADDR       = 5'h1E;
  localparam logic [4:0] CTRL_ADDR       = 5'h1F;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0] LED_CFG3_RST = 16'h0002;
  localparam logic [15:0] CFG4_RST     = 16'h0012;
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [15:0] INT_MASK_RST = 16'h0000;
  localparam logic [15:0] CFG4_WR_MASK = 16'hFFF8;
  localparam logic [15:0] CTRL_WR_MASK = 16'h3FFF;
  localparam logic [15:0] LED_WR_MASK  = 16'h0007;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned LED_RATE_LSB     = 0;
  localparam int unsigned LED_BYPASS_BIT   = 2;
  localparam int unsigned QNEG_EN_BIT      = 14;
  localparam int unsigned QNEG_SEL_LSB     = 12;
  localparam int unsigned PD_FULL_BIT      = 11;
  localparam int unsigned STATUS_CLR_BIT   = 10;
  localparam int unsigned ROBUST_XOVER_BIT = 9;
  localparam int unsigned QUICK_XOVER_BIT  = 8;
  localparam int unsigned PAD_IRQ_BIT      = 7;
  localparam int unsigned FORCE_IRQ_BIT    = 6;
  localparam int unsigned GIG_ONLY_BIT     = 3;
  localparam int unsigned TEST_FAIL_BIT    = 2;
  localparam int unsigned TEST_DONE_BIT    = 1;
  localparam int unsigned TEST_START_BIT   = 0;
  localparam int unsigned FULL_RESET_BIT   = 15;
  localparam int unsigned RELAUNCH_BIT     = 14;

  // ----------------------------------------------------------------
  // Interrupt event positions
  // ----------------------------------------------------------------
  localparam int unsigned EVT_TEST_DONE  = 0;
  localparam int unsigned EVT_TEST_FAIL  = 1;
  localparam int unsigned EVT_RELAUNCH   = 2;
  localparam int unsigned EVT_STATUS_CLR = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned BLINK_MS_0   = 50;
  localparam int unsigned BLINK_MS_1   = 100;
  localparam int unsigned BLINK_MS_2   = 200;
  localparam int unsigned BLINK_MS_3   = 500;
  // The LED toggles twice per blink period, so each count is half a period.
  localparam int unsigned BLINK_HALF_0 = (CLK_HZ / 1000) * BLINK_MS_0 / 2;
  localparam int unsigned BLINK_HALF_1 = (CLK_HZ / 1000) * BLINK_MS_1 / 2;
  localparam int unsigned BLINK_HALF_2 = (CLK_HZ / 1000) * BLINK_MS_2 / 2;
  localparam int unsigned BLINK_HALF_3 = (CLK_HZ / 1000) * BLINK_MS_3 / 2;

endpackage : phy_cfg_pkg

`default_nettype wire

// ### core/cable_test_if.sv
`default_nettype none

interface cable_test_if;
  logic start;
  logic busy;
  logic fail;
  logic done_evt;

  modport ctrl (output start, input busy, input fail, input done_evt);
  modport seq  (input start, output busy, output fail, output done_evt);
endinterface : cable_test_if

`default_nettype wire

// ### core/led_blink_gen.sv
`default_nettype none

module led_blink_gen #(
  parameter int unsigned HALF_0 = phy_cfg_pkg::BLINK_HALF_0,
  parameter int unsigned HALF_1 = phy_cfg_pkg::BLINK_HALF_1,
  parameter int unsigned HALF_2 = phy_cfg_pkg::BLINK_HALF_2,
  parameter int unsigned HALF_3 = phy_cfg_pkg::BLINK_HALF_3
) (
  input  wire logic       clk,      // core clock
  input  wire logic       rst_n,    // synchronised reset, active low
  input  wire logic [1:0] sel,      // blink period select
  output var  logic       blink     // blink phase
);

  if (HALF_0 < 1 || HALF_1 < 1 || HALF_2 < 1 || HALF_3 < 1)
  begin : g_bad_half
    $error("blink counts must be at least one");
  end

  logic [31:0] cnt_ff;
  logic [31:0] limit;
  logic        wrap;

  assign limit = (sel == 2'h0) ? HALF_0 - 1 :
                 (sel == 2'h1) ? HALF_1 - 1 :
                 (sel == 2'h2) ? HALF_2 - 1 : HALF_3 - 1;
  // Using >= lets a shorter period take effect at once after a change.
  assign wrap  = cnt_ff >= limit;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 32'h0;
      blink  <= 1'b0;
    end
    else
    begin
      cnt_ff <= wrap ? 32'h0 : cnt_ff + 32'h1;
      blink  <= wrap ? ~blink : blink;
    end
  end

endmodule : led_blink_gen

`default_nettype wire

// ### core/cable_test_seq.sv
`default_nettype none

module cable_test_seq (
  input  wire logic clk,          // core clock
  input  wire logic rst_n,        // synchronised reset, active low
  input  wire logic abort,        // soft full reset, drops any test
  cable_test_if.seq ct,           // control side
  output var  logic eng_run,      // run request to the test engine
  input  wire logic eng_done,     // engine finished, one-cycle pulse
  input  wire logic eng_fail      // engine verdict, valid with eng_done
);

  typedef enum logic {IDLE, RUN} state_t;
  state_t state_ff;

  assign eng_run = (state_ff == RUN);
  assign ct.busy = (state_ff == RUN);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff    <= IDLE;
      ct.fail     <= 1'b0;
      ct.done_evt <= 1'b0;
    end
    else if (abort)
    begin
      state_ff    <= IDLE;
      ct.fail     <= 1'b0;
      ct.done_evt <= 1'b0;
    end
    else
    begin
      ct.done_evt <= 1'b0;
      unique case (state_ff)
        IDLE:
        begin
          if (ct.start)
            state_ff <= RUN;
        end
        RUN:
        begin
          if (eng_done)
          begin
            state_ff    <= IDLE;
            ct.fail     <= eng_fail;
            ct.done_evt <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule : cable_test_seq

`default_nettype wire

// ### testbench/phy_general_config_ctrl_props.sv
`default_nettype none

module phy_general_config_ctrl_props (
  input wire logic        clk,                       // clock
  input wire logic        rstn,                      // reset, active low
  input wire logic [4:0]  reg_addr,                  // address
  input wire logic [15:0] reg_wdata,                 // write data
  input wire logic        reg_wr,                    // write strobe
  input wire logic        reg_rd,                    // read strobe
  input wire logic [15:0] reg_rdata,                 // read data
  input wire logic        phy_status_clear,          // status clear pulse
  input wire logic        phy_full_reset,            // full reset pulse
  input wire logic        phy_relaunch,              // restart pulse
  input wire logic        cable_test_run,            // test running
  input wire logic        cable_test_eng_done,       // engine done
  input wire logic        irq_or_powerdown_pad_o,    // pad level
  input wire logic        irq_or_powerdown_pad_oe_n  // pad drive
);
  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire logic wr4 = reg_wr && reg_addr == 5'h1E;
  wire logic wrc = reg_wr && reg_addr == 5'h1F;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_relaunch; wrc && reg_wdata[14] |=> phy_relaunch; endproperty
  property p_full_reset; wrc && reg_wdata[15] |=> phy_full_reset; endproperty
  property p_status_clear; wr4 && reg_wdata[10] |=> phy_status_clear; endproperty
  property p_run_start; wr4 && reg_wdata[0] && !cable_test_run |=> cable_test_run; endproperty
  property p_run_end; cable_test_run && cable_test_eng_done |=> !cable_test_run; endproperty
  property p_pad_drive; wr4 && reg_wdata[7] |-> ##[1:2] !irq_or_powerdown_pad_oe_n; endproperty
  property p_force_irq; wr4 && reg_wdata[6] |-> ##[1:2] !irq_or_powerdown_pad_o; endproperty
  property p_read_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  property p_cmd_zero; reg_rd && reg_addr == 5'h1F |=> reg_rdata[15:14] == 2'h0; endproperty

  a_relaunch: assert property (p_relaunch) else $error("restart pulse missing");
  a_full_reset: assert property (p_full_reset) else $error("reset pulse missing");
  a_status_clear: assert property (p_status_clear) else $error("clear pulse missing");
  a_run_start: assert property (p_run_start) else $error("test did not start");
  a_run_end: assert property (p_run_end) else $error("test did not end");
  a_pad_drive: assert property (p_pad_drive) else $error("pad not driven");
  a_force_irq: assert property (p_force_irq) else $error("pad not asserted");
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");
  a_cmd_zero: assert property (p_cmd_zero) else $error("command bits read set");

  c_full_reset: cover property (phy_full_reset);
  c_test_end: cover property (cable_test_run && cable_test_eng_done);
  c_forced: cover property (!irq_or_powerdown_pad_o);
endmodule : phy_general_config_ctrl_props

bind phy_general_config_ctrl phy_general_config_ctrl_props u_props (
  .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phy_status_clear,
  .phy_full_reset, .phy_relaunch, .cable_test_run, .cable_test_eng_done,
  .irq_or_powerdown_pad_o, .irq_or_powerdown_pad_oe_n
);

`default_nettype wire

// ### testbench/phy_general_config_ctrl_bench.sv
`default_nettype none

module phy_general_config_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF [4] = '{4, 8, 16, 40};
  logic clk, rstn, reg_wr, reg_rd, manual_speed_1g, cable_test_eng_done, cable_test_eng_fail;
  logic phy_irq_req, irq_or_powerdown_pad_i, led_blink, led_stretch_bypass, irq, neg_skip;
  logic quick_negotiation_enable, parallel_detect_full_duplex_enable, robust_crossover_enable;
  logic quick_crossover_enable, neg_gig_only, phy_status_clear, phy_full_reset, phy_relaunch;
  logic cable_test_run, irq_or_powerdown_pad_o, irq_or_powerdown_pad_oe_n, power_down_req, b;
  logic [1:0]  quick_negotiation_timer_sel;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, strap_cfg4, lfsr, v;
  int          miscompares, checked, sts, n;

  // The short blink counts keep each period measurable in a few dozen cycles.
  phy_general_config_ctrl #(.BLINK_HALF_0(HALF[0]), .BLINK_HALF_1(HALF[1]),
    .BLINK_HALF_2(HALF[2]), .BLINK_HALF_3(HALF[3]), .STRAP_MASK(16'h0100)) u_dut (
    .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .strap_cfg4, .led_blink,
    .led_stretch_bypass, .quick_negotiation_enable, .quick_negotiation_timer_sel,
    .parallel_detect_full_duplex_enable, .robust_crossover_enable, .quick_crossover_enable,
    .manual_speed_1g, .neg_gig_only, .neg_skip, .phy_status_clear, .phy_full_reset,
    .phy_relaunch, .cable_test_run, .cable_test_eng_done, .cable_test_eng_fail, .phy_irq_req,
    .irq_or_powerdown_pad_i, .irq_or_powerdown_pad_o, .irq_or_powerdown_pad_oe_n,
    .power_down_req, .irq);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] e, input string name);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(name, e, reg_rdata);
  endtask : rd

  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial
  begin
    {reg_wr, reg_rd, cable_test_eng_done, cable_test_eng_fail, phy_irq_req, rstn} = '0;
    {manual_speed_1g, reg_addr, reg_wdata} = '0;
    irq_or_powerdown_pad_i = 1'b1;
    strap_cfg4 = 16'h0100;
    lfsr = 16'h0042;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(5'h1E, 16'h0112, "cfg4 reset");
    rd(5'h1F, 16'h0000, "ctrl reset");
    rd(5'h1A, 16'h0002, "led reset");
    rd(5'h1C, 16'h0000, "mask reset");
    rd(5'h05, 16'h0000, "unmapped");
    for (int s = 0; s < 4; s++)
    begin
      wr(5'h1A, 16'(s + 4 * (s % 2)));
      rd(5'h1A, 16'(s + 4 * (s % 2)), "led cfg");
      chk("bypass", 16'(s % 2), 16'(led_stretch_bypass));
      for (int k = 0; k < 2; k++)
      begin
        b = led_blink;
        n = 0;
        while (led_blink === b && n < 200)
        begin
          @(negedge clk);
          n++;
        end
      end
      chk("blink half period", 16'(HALF[s]), 16'(n));
    end
    // Reserved bits keep their reset levels and the start bit stays clear here.
    for (int i = 0; i < 6; i++)
    begin
      lfsr = lfsr_next(lfsr);
      v = (lfsr & 16'h7FC8) | 16'h0010;
      wr(5'h1E, v);
      manual_speed_1g <= lfsr[1];
      irq_or_powerdown_pad_i <= lfsr[2];
      phy_irq_req <= lfsr[3];
      if (v[10])
        sts = sts | 8;
      rd(5'h1E, v | 16'h0002, "cfg4");
      chk("config outputs", 16'({v[14:11], v[9:8], lfsr[1] & v[3], lfsr[1] & ~v[3], ~v[7],
        ~(v[6] | lfsr[3]), ~v[7] & ~lfsr[2]}), 16'({quick_negotiation_enable,
        quick_negotiation_timer_sel, parallel_detect_full_duplex_enable, robust_crossover_enable,
        quick_crossover_enable, neg_gig_only, neg_skip, irq_or_powerdown_pad_oe_n,
        irq_or_powerdown_pad_o, power_down_req}));
    end
    rd(5'h1B, 16'(sts), "status clear event");
    wr(5'h1C, 16'h000F);
    wr(5'h1E, 16'h0011);
    rd(5'h1E, 16'h0011, "cfg4 busy");
    @(posedge clk);
    cable_test_eng_done <= 1'b1;
    cable_test_eng_fail <= 1'b1;
    @(posedge clk);
    cable_test_eng_done <= 1'b0;
    cable_test_eng_fail <= 1'b0;
    repeat (3) @(negedge clk);
    chk("irq and run", 16'h0002, 16'({irq, cable_test_run}));
    rd(5'h1E, 16'h0016, "cfg4 fail");
    rd(5'h1B, 16'h0003, "status test");
    rd(5'h1B, 16'h0000, "status cleared");
    chk("irq cleared", 16'h0000, 16'(irq));
    wr(5'h1C, 16'h0000);
    wr(5'h1F, 16'h4ABC);
    rd(5'h1F, 16'h0ABC, "restart keeps");
    chk("irq masked", 16'h0000, 16'(irq));
    rd(5'h1B, 16'h0004, "status restart");
    wr(5'h1A, 16'h0005);
    wr(5'h1F, 16'h9234);
    rd(5'h1F, 16'h0000, "ctrl after reset");
    rd(5'h1E, 16'h0112, "cfg4 after reset");
    rd(5'h1A, 16'h0002, "led after reset");
    finish_test();
  end
endmodule : phy_general_config_ctrl_bench

`default_nettype wire
